// [verilog/supply_monitor_sequencer.sv]
// Purpose: Core regulator sequencing, MCU reset and supply warning IRQ.
// Assumes: All inputs are synchronous to clk; 100 MHz clock.
// Notes: Registers are reached over the die-to-die port.
// Notes on behaviour
// - Enable bit 4 gates regulator over-voltage interrupt.
// - Enable bit 3 gates high-temperature interrupt.
// - Enable bit 2 gates driver supply high interrupt.
// - Enable bit 1 gates main supply low interrupt.
// - Enable bit 0 gates battery low interrupt.
// - Core regulator waits for I/O rail valid.
// - MCU reset held until core rail valid.
// - I/O rail low disables and discharges core.
// - Same power-down event asserts MCU reset.
// - Registers decoded above 0x200 and 0x300.
// - Five separate supply warning events.
// - Separate core and I/O undervoltage conditions.
// - Status read clears pending warning flags.
`timescale 1ns/10ps
`include "supply_seq_map.svh"
module supply_monitor_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input supply_seq_pkg::d2d_req_t die_to_die_port,
    output logic [7:0] rdata_q,
    input supply_seq_pkg::warn_t warn_cond,
    input wire logic core_undervoltage_reset,
    input wire logic io_undervoltage_reset,
    output logic core_reg_en_q,
    output logic core_discharge_q,
    output logic mcu_reset_n_q,
    output logic supply_irq_q
);
    import supply_seq_pkg::*;

    // Sequencer state and its next value.
    seq_state_t state_q, state_d;
    // Next values of the regulator and reset outputs.
    logic core_en_d, discharge_d, reset_n_d;

    // Power sequencing: the core rail only ever runs while the I/O rail
    // is valid, so the MCU never sees a core rail above its own POR
    // level with a dead reset circuit.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SEQ_OFF: begin
                // Hold the core off until the I/O rail is valid.
                if (!io_undervoltage_reset) begin
                    state_d = SEQ_RAMP;
                end
            end
            SEQ_RAMP: begin
                // I/O collapse wins over the core reaching its level.
                if (io_undervoltage_reset) begin
                    state_d = SEQ_OFF;
                end else if (!core_undervoltage_reset) begin
                    state_d = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                // Power-down: drop the core and reset the MCU together.
                if (io_undervoltage_reset) begin
                    state_d = SEQ_OFF;
                end
            end
            default: begin
                // An illegal code falls back to the safe state.
                state_d = SEQ_OFF;
            end
        endcase
        core_en_d = (state_d != SEQ_OFF);
        discharge_d = (state_d == SEQ_OFF);
        reset_n_d = (state_d == SEQ_RUN);
    end

    // Register state and outputs together so they change on one edge.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= SEQ_OFF;
            core_reg_en_q <= 1'b0;
            core_discharge_q <= 1'b1;
            mcu_reset_n_q <= 1'b0;
        end else begin
            state_q <= state_d;
            core_reg_en_q <= core_en_d;
            core_discharge_q <= discharge_d;
            mcu_reset_n_q <= reset_n_d;
        end
    end

    // Address decode: both windows reach the same registers.
    logic hit_blk, hit_nblk, hit;
    logic [9:0] ofs_full;
    logic [7:0] ofs;
    always_comb begin
        hit_blk = (die_to_die_port.addr >= `SUP_BASE_BLK) &&
                  (die_to_die_port.addr < `SUP_BASE_BLK + `SUP_WIN_SIZE);
        // The upper window ends at the top of the address space, so its
        // bound is formed one bit wider; at ten bits it would wrap to zero.
        hit_nblk = (die_to_die_port.addr >= `SUP_BASE_NBLK) &&
                   ({1'b0, die_to_die_port.addr} <
                    ({1'b0, `SUP_BASE_NBLK} + {1'b0, `SUP_WIN_SIZE}));
        hit = hit_blk | hit_nblk;
        ofs_full = die_to_die_port.addr -
                   (hit_nblk ? `SUP_BASE_NBLK : `SUP_BASE_BLK);
        ofs = ofs_full[7:0];
    end

    // Enable register and read data.
    logic [4:0] irq_en_q, irq_en_d;
    logic [7:0] rdata_d;
    logic status_rd;
    warn_t flags;
    logic [6:0] status_now;

    // Live conditions; the two undervoltage bits stay apart.
    always_comb begin
        status_now = {io_undervoltage_reset, core_undervoltage_reset,
                      warn_cond};
    end

    // Writes update the enable; reads latch the addressed byte.
    always_comb begin
        irq_en_d = irq_en_q;
        rdata_d = rdata_q;
        status_rd = 1'b0;
        if (die_to_die_port.wr && hit && ofs == `SUP_OFS_IRQ_EN) begin
            irq_en_d = die_to_die_port.wdata[4:0];
        end
        if (die_to_die_port.rd) begin
            // Unmapped offsets read as zero.
            rdata_d = `SUP_RDATA_RST;
            if (hit && ofs == `SUP_OFS_IRQ_EN) begin
                rdata_d = {3'h0, irq_en_q};
            end else if (hit && ofs == `SUP_OFS_STATUS) begin
                rdata_d = {1'b0, status_now};
                status_rd = 1'b1;
            end else if (hit && ofs == `SUP_OFS_FLAGS) begin
                rdata_d = {3'h0, flags};
            end
        end
    end

    // Register the enable byte and the read data.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_en_q <= `SUP_IRQ_EN_RST;
            rdata_q <= `SUP_RDATA_RST;
        end else begin
            irq_en_q <= irq_en_d;
            rdata_q <= rdata_d;
        end
    end

    // A warning raises its event on the rising edge of its condition,
    // so a condition that stays present does not refill after a clear.
    warn_t cond_q, rise;
    always_comb begin
        rise = warn_cond & ~cond_q;
    end

    // Remember each condition for edge detection.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cond_q <= '0;
        end else begin
            cond_q <= warn_cond;
        end
    end

    // Pending flags; a status read clears, a fresh event wins.
    sticky_flags #(
        .N(5)
    ) u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .set_i(rise),
        .clr_i(status_rd),
        .flags_q(flags)
    );

    // Interrupt gating: each flag only counts with its enable bit.
    logic irq_d;
    always_comb begin
        irq_d = (flags.reg_overvolt & irq_en_q[`SUP_BIT_OVERVOLT]) |
            (flags.hot_regulator & irq_en_q[`SUP_BIT_HOT_REG]) |
            (flags.driver_supply_high & irq_en_q[`SUP_BIT_DRV_HIGH]) |
            (flags.main_supply_low & irq_en_q[`SUP_BIT_MAIN_LOW]) |
            (flags.battery_low & irq_en_q[`SUP_BIT_BATT_LOW]);
    end

    // The request is registered so the port comes from a flip-flop.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            supply_irq_q <= 1'b0;
        end else begin
            supply_irq_q <= irq_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_core_waits_io: assert property (
        (state_q == SEQ_OFF && io_undervoltage_reset) |=> !core_reg_en_q)
        else $error("Core enabled while I/O rail invalid.");
    a_core_starts: assert property (
        (state_q == SEQ_OFF && !io_undervoltage_reset) |=> core_reg_en_q)
        else $error("Core not enabled after I/O rail valid.");
    a_reset_holds: assert property (
        (!mcu_reset_n_q && core_undervoltage_reset) |=> !mcu_reset_n_q)
        else $error("MCU reset released before core rail valid.");
    a_reset_release: assert property (
        (core_reg_en_q && !io_undervoltage_reset && !core_undervoltage_reset)
        |=> mcu_reset_n_q)
        else $error("MCU reset not released.");
    a_core_shutdown: assert property (
        (core_reg_en_q && io_undervoltage_reset)
        |=> (!core_reg_en_q && core_discharge_q))
        else $error("Core not shut down and discharged.");
    a_reset_on_down: assert property (
        (mcu_reset_n_q && io_undervoltage_reset) |=> !mcu_reset_n_q)
        else $error("MCU reset not asserted at power-down.");
    a_enable_window: assert property (
        (die_to_die_port.wr &&
         (die_to_die_port.addr == `SUP_BASE_NBLK + 10'h012))
        |=> irq_en_q == $past(die_to_die_port.wdata[4:0]))
        else $error("Enable not written through the upper window.");
    a_event_flags: assert property (
        (rise != 5'h00) |=> ((flags & $past(rise)) == $past(rise)))
        else $error("Warning event did not set its flag.");
    a_uv_distinct: assert property (
        (die_to_die_port.rd && hit && ofs == `SUP_OFS_STATUS)
        |=> rdata_q[6:5] == $past({io_undervoltage_reset,
                                   core_undervoltage_reset}))
        else $error("Undervoltage bits wrong in status.");
    a_read_clears: assert property (
        (status_rd && rise == 5'h00) |=> flags == 5'h00)
        else $error("Status read did not clear flags.");
    a_irq_gate: assert property (
        ##1 supply_irq_q == |($past(flags) & $past(irq_en_q)))
        else $error("Interrupt does not follow enabled flags.");

    c_power_up: cover property (
        (state_q == SEQ_OFF) ##[1:20] mcu_reset_n_q);
    c_power_down: cover property (mcu_reset_n_q ##1 !core_reg_en_q);
    c_irq_cleared: cover property (supply_irq_q ##[1:5] status_rd
        ##[1:3] !supply_irq_q);

endmodule

// [include/supply_seq_map.svh]
// Purpose: Offsets, field positions, reset values of the supply sequencer.
// Assumes: 10-bit global addresses from the die-to-die port.
// Notes: Every register is one byte wide.
`ifndef SUPPLY_SEQ_MAP_SVH
`define SUPPLY_SEQ_MAP_SVH

// Window bases for blocking and non-blocking accesses.
`define SUP_BASE_BLK 10'h200
`define SUP_BASE_NBLK 10'h300
`define SUP_WIN_SIZE 10'h100

// Register offsets inside either window.
`define SUP_OFS_IRQ_EN 8'h12
`define SUP_OFS_STATUS 8'h13
`define SUP_OFS_FLAGS 8'h14

// Field positions shared by enable, status and flag registers.
`define SUP_BIT_BATT_LOW 0
`define SUP_BIT_MAIN_LOW 1
`define SUP_BIT_DRV_HIGH 2
`define SUP_BIT_HOT_REG 3
`define SUP_BIT_OVERVOLT 4
`define SUP_BIT_CORE_UV 5
`define SUP_BIT_IO_UV 6

// Reset values.
`define SUP_IRQ_EN_RST 5'h00
`define SUP_RDATA_RST 8'h00

`endif

// [include/supply_seq_pkg.sv]
// Purpose: Types shared by the supply sequencer files.
// Assumes: Offsets and fields live in supply_seq_map.svh.
// Notes: Warning structs are packed with bit 4 first, bit 0 last.
package supply_seq_pkg;

    // Five supply warnings in register bit order, bit 4 down to bit 0.
    typedef struct packed {
        logic reg_overvolt;
        logic hot_regulator;
        logic driver_supply_high;
        logic main_supply_low;
        logic battery_low;
    } warn_t;

    // One register access from the die-to-die port.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } d2d_req_t;

    // Power sequencer states, one-hot.
    typedef enum logic [2:0] {
        SEQ_OFF = 3'b001,
        SEQ_RAMP = 3'b010,
        SEQ_RUN = 3'b100
    } seq_state_t;

endpackage

// [verilog/sticky_flags.sv]
// Purpose: Bank of sticky event flags with a common clear.
// Assumes: Set and clear are one-cycle pulses on clk.
// Notes: A set in the cycle of a clear wins, so no event is lost.
`timescale 1ns/10ps
module sticky_flags #(
    parameter int N = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] set_i,
    input wire logic clr_i,
    output logic [N-1:0] flags_q
);

    // Next value of every flag.
    logic [N-1:0] flags_d;

    // Each flag is kept alone so a clear never hides a fresh event.
    for (genvar i = 0; i < N; i++) begin : g_flag
        always_comb begin
            flags_d[i] = set_i[i] | (flags_q[i] & ~clr_i);
        end
    end

    // Register the flags; reset leaves nothing pending.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule

// [tb/d2d_master_model.sv]
// Purpose: MCU side master issuing single byte register accesses.
// Assumes: One access at a time; fields change just after a clock edge.
// Notes: Released fields show inverted values so stale data never matches.
`timescale 1ns/10ps
module d2d_master_model (
    input wire logic clk,
    output supply_seq_pkg::d2d_req_t req,
    input wire logic [7:0] rdata
);
    import supply_seq_pkg::*;

    // The bus is idle at time zero.
    initial req = '0;

    // Strobe for one cycle, release, then fetch the registered answer.
    task automatic access(input logic rd, input logic [9:0] addr,
                          input logic [7:0] wdata, output logic [7:0] data);
        @(posedge clk);
        req <= '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
        @(posedge clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        // Waiting one extra edge is safe because read data holds.
        @(posedge clk);
        #1 data = rdata;
    endtask
endmodule

// [tb/test_supply_monitor_sequencer.sv]
// Purpose: Self-checking bench for the supply monitor sequencer.
// Assumes: Integer model of rails, enables and flags runs beside it.
// Notes: Warnings rise together from a random mask per round and clear at its end so every rise is fresh.
`timescale 1ns/10ps
`include "supply_seq_map.svh"
module test_supply_monitor_sequencer;
    import supply_seq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    d2d_req_t die_to_die_port;
    logic [7:0] rdata_q;
    warn_t warn_cond = '0;
    logic core_uv = 1'b1;
    logic io_uv = 1'b1;
    logic core_reg_en_q, core_discharge_q, mcu_reset_n_q, supply_irq_q;
    int miscompares = 0;
    int num_checks = 0;
    int st = 0; // Model state: 0 off, 1 ramp, 2 run.
    int en_m = 0; // Model enables.
    int flag_m = 0; // Model pending flags.
    logic [31:0] seed = 32'h0F2579A6;
    logic [31:0] r;
    logic [9:0] base;
    logic [1:0] rail_seq [6] = '{2'b10, 2'b01, 2'b00, 2'b10, 2'b00, 2'b00};

    // Free running 100 MHz clock.
    always #5 clk = ~clk;

    supply_monitor_sequencer i_supply_monitor_sequencer (
        .clk(clk), .rst_n(rst_n), .die_to_die_port(die_to_die_port),
        .rdata_q(rdata_q), .warn_cond(warn_cond),
        .core_undervoltage_reset(core_uv), .io_undervoltage_reset(io_uv),
        .core_reg_en_q(core_reg_en_q), .core_discharge_q(core_discharge_q),
        .mcu_reset_n_q(mcu_reset_n_q), .supply_irq_q(supply_irq_q));

    d2d_master_model i_d2d_master_model (
        .clk(clk), .req(die_to_die_port), .rdata(rdata_q));

    // Fixed seed xorshift keeps every run identical.
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Compare one read byte with the model.
    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Compare enable, discharge, reset and interrupt pins with the model.
    task automatic cmp_pins();
        logic [3:0] g;
        logic [3:0] e;
        g = {core_reg_en_q, core_discharge_q, mcu_reset_n_q, supply_irq_q};
        e = {st != 0, st == 0, st == 2, (flag_m & en_m) != 0};
        cmp_byte({4'h0, g}, {4'h0, e});
    endtask

    // Register read through the partner, checked against a value.
    task automatic reg_rd(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] g;
        i_d2d_master_model.access(1'b1, a, 8'h00, g);
        cmp_byte(g, e);
    endtask

    // Register write through the partner.
    task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] g;
        i_d2d_master_model.access(1'b0, a, d, g);
    endtask

    // Drive rail conditions; outputs follow one cycle later.
    task automatic rails(input logic io, input logic core);
        @(posedge clk);
        io_uv <= io;
        core_uv <= core;
        @(posedge clk);
        #1;
        if (io) st = 0;
        else if (st == 0) st = 1;
        else if (st == 1 && !core) st = 2;
        cmp_pins();
    endtask

    // Print counts and the verdict, then end the run.
    task automatic stop_test();
        $display("Checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the expected run length.
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 cmp_pins();
        reg_rd(10'h212, 8'h00);
        reg_rd(10'h213, 8'h60);
        reg_wr(10'h112, 8'hFF);
        reg_rd(10'h312, 8'h00);
        reg_rd(10'h2FF, 8'h00);
        $display("Test registers done");
        foreach (rail_seq[i]) rails(rail_seq[i][1], rail_seq[i][0]);
        $display("Test sequencing done");
        for (int i = 0; i < 16; i++) begin
            r = xorshift();
            base = r[31] ? `SUP_BASE_NBLK : `SUP_BASE_BLK;
            reg_wr(base + 10'h012, r[7:0]);
            en_m = r[4:0];
            // Read back through the other window: both reach one register.
            reg_rd((base ^ 10'h100) + 10'h012, {3'h0, r[4:0]});
            @(posedge clk);
            warn_cond <= r[12:8];
            repeat (2) @(posedge clk);
            #1 flag_m = r[12:8];
            cmp_pins();
            reg_rd(base + 10'h014, {3'h0, r[12:8]});
            reg_rd(base + 10'h013, {3'h0, r[12:8]});
            flag_m = 0;
            cmp_pins();
            @(posedge clk);
            warn_cond <= '0;
        end
        $display("Test interrupts done");
        stop_test();
    end
endmodule
